// File: core/celf_core.sv
// Purpose: coincidence event list framer core
// Assumes: converter pins asynchronous, one core clock
// Notes: word stream leaves byte 0 (bits 7:0) first
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "celf_regs.svh"
module celf_core #(
	parameter int MS_CYC = `CELF_MS_NS / `CELF_CLK_NS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register port
	input wire celf_pkg::celf_req_t regReq,
	output logic [31:0] regRdData,
	// converter handshake pins
	input wire logic [15:0] conversionReadyIn,
	input wire logic [15:0] busyIn,
	input wire logic [255:0] sampleIn,
	input wire logic vetoInput,
	input wire logic rtcExtClk,
	// list stream toward the host fifo
	output celf_pkg::celf_word_t listOut,
	input wire logic listReady
);
	localparam int NCH = 16;
	////////////////////////////////////////////////////////////////////
	// lowest set channel of a mask
	function automatic logic [3:0] lowIdx(input logic [15:0] m);
		lowIdx = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (m[i]) begin
				lowIdx = 4'(i);
			end
		end
	endfunction
	// register offset hit
	function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
		hit = (a == o);
	endfunction
	// last count of the timer reduction
	function automatic logic [9:0] redLimit(input logic [1:0] s);
		redLimit = (s == 2'h0) ? 10'h000 : (s == 2'h1) ? 10'h009 :
			(s == 2'h2) ? 10'h063 : 10'h3E7;
	endfunction
	////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	logic [15:0] rdyS1_q, rdyS2_q, rdyP_q, bsyS1_q, bsyS2_q, bsyP_q;
	logic [255:0] datS1_q, datS2_q;
	logic vetS1_q, vetS2_q, vetP_q, extS1_q, extS2_q, extP_q;
	// software registers
	logic [8:0] ctrl_q;
	logic [1:0] pol_q;
	logic [16:0] any_q;
	logic [15:0] start_q, win_q, tmo_q;
	logic [16:0] dep_q [4];
	logic [31:0] preLo_q;
	// sequencer state
	celf_pkg::celf_st_t st_q;
	logic [15:0] cnt_q, toc_q, hit_q, done_q, dmask_q, left_q, lo_q;
	logic [15:0] smp_q [NCH];
	logic vetHit_q, fill_q, loHeld_q, needSync_q, tmrPend_q;
	logic [1:0] eph_q, rtcLeft_q;
	logic [47:0] rtc_q, rtcCap_q;
	logic [4:0] acc_q;
	logic [15:0] ms_q;
	logic [9:0] red_q;
	logic [31:0] outWord_q;
	logic outValid_q;
	////////////////////////////////////////////////////////////////////
	// synchroniser chains; the P flops hold the previous active level
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{rdyS1_q, rdyS2_q, bsyS1_q, bsyS2_q} <= 64'h0;
			{datS1_q, datS2_q} <= 512'h0;
			{vetS1_q, vetS2_q, extS1_q, extS2_q} <= 4'h0;
		end else begin
			{rdyS1_q, rdyS2_q} <= {conversionReadyIn, rdyS1_q};
			{bsyS1_q, bsyS2_q} <= {busyIn, bsyS1_q};
			{datS1_q, datS2_q} <= {sampleIn, datS1_q};
			{vetS1_q, vetS2_q} <= {vetoInput, vetS1_q};
			{extS1_q, extS2_q} <= {rtcExtClk, extS1_q};
		end
	end
	// per-signal polarity: ready bit 0, busy bit 1, set means active low
	wire [15:0] rdyAct = rdyS2_q ^ {NCH{pol_q[0]}};
	wire [15:0] bsyAct = bsyS2_q ^ {NCH{pol_q[1]}};
	// rising edge for positive veto, falling for negative
	wire vetAct = vetS2_q ^ ctrl_q[`CELF_C_VNEG];
	wire [15:0] rdyEdge = rdyAct & ~rdyP_q;
	wire [15:0] bsyEdge = bsyAct & ~bsyP_q;
	wire vetEdge = ctrl_q[`CELF_C_VEN] & vetAct & ~vetP_q;
	wire extTick = extS2_q & ~extP_q;
	// previous levels for edge detection
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{rdyP_q, bsyP_q, vetP_q, extP_q} <= 34'h0;
		end else begin
			{rdyP_q, bsyP_q, vetP_q, extP_q} <=
				{rdyAct, bsyAct, vetAct, extS2_q};
		end
	end
	////////////////////////////////////////////////////////////////////
	// control decode
	wire run = ctrl_q[`CELF_C_RUN];
	wire coinc = ctrl_q[`CELF_C_COINC];
	wire rtcOn = ctrl_q[`CELF_C_RTC];
	wire stIdle = (st_q == celf_pkg::ST_IDLE);
	wire stWin = (st_q == celf_pkg::ST_WIN);
	wire stWait = (st_q == celf_pkg::ST_WAIT);
	wire stEmit = (st_q == celf_pkg::ST_EMIT);
	// output slot free, stalls while host fifo is full
	wire advance = !outValid_q || listReady;
	wire fifoFull = outValid_q && !listReady;
	// window opening and membership
	wire [15:0] startHit = bsyEdge & start_q;
	wire openWin = stIdle && run && coinc && (startHit != 16'h0);
	wire [15:0] joinB = openWin ? startHit : (stWin ? bsyEdge : 16'h0);
	// single mode watches ready only; coincidence only busy members
	wire [15:0] capSingle = (stIdle && run && !coinc) ? rdyEdge : 16'h0;
	wire [15:0] capCoin = (stWin || stWait) ? (rdyEdge & hit_q) : 16'h0;
	wire [15:0] capMask = capSingle | capCoin;
	wire goSingle = capSingle != 16'h0;
	// window end: full length, or at once on instant veto
	wire vetNow = stWin && vetEdge && !ctrl_q[`CELF_C_VEND];
	wire winEnd = stWin && ((cnt_q == 16'h0) || vetNow);
	// group evaluation, veto is member bit 16
	wire [16:0] valid = {vetHit_q, done_q};
	wire anyOk = (any_q & valid) != 17'h0;
	logic [3:0] depOk;
	for (genvar g = 0; g < 4; g++) begin : gDep
		assign depOk[g] = (dep_q[g] != 17'h0) &&
			((dep_q[g] & valid) == dep_q[g]);
	end
	wire accept = anyOk || (depOk != 4'h0);
	wire waitDone = stWait && (((hit_q & ~done_q) == 16'h0) ||
		(toc_q == 16'h0));
	wire goEmit = goSingle || (waitDone && accept);
	////////////////////////////////////////////////////////////////////
	// timer words and sync marks
	wire msTick = ms_q == 16'(MS_CYC - 1);
	wire tmrDue = msTick && (red_q == redLimit(ctrl_q[3:2]));
	wire tmrOut = run && tmrPend_q && !stEmit && advance;
	wire syncNeeded = needSync_q || tmrOut;
	// emission phases: 0 sync, 1 event word, 2 half words
	wire halfEmpty = (rtcLeft_q == 2'h0) && !fill_q && (left_q == 16'h0);
	wire [15:0] rtcPart = (rtcLeft_q == 2'h3) ? rtcCap_q[15:0] :
		(rtcLeft_q == 2'h2) ? rtcCap_q[31:16] : rtcCap_q[47:32];
	wire [15:0] nextHw = (rtcLeft_q != 2'h0) ? rtcPart :
		fill_q ? `CELF_FILL : smp_q[lowIdx(left_q)];
	wire emitGo = stEmit && advance;
	wire syncOut = emitGo && (eph_q == 2'h0);
	wire evtOut = emitGo && (eph_q == 2'h1);
	wire halfStep = emitGo && (eph_q == 2'h2) && !halfEmpty;
	wire pairOut = halfStep && loHeld_q;
	wire flushOut = emitGo && (eph_q == 2'h2) && halfEmpty && loHeld_q;
	wire emitEnd = emitGo && (eph_q == 2'h2) && halfEmpty && !loHeld_q;
	wire [31:0] evtWord = {fill_q, 1'b0, 1'b0, rtcOn, 12'h000,
		dmask_q};
	wire wordOut = tmrOut || syncOut || evtOut || pairOut || flushOut;
	// lower channel low, next channel high; live is bit set when idle
	wire [31:0] nextWord = tmrOut ? {`CELF_TMR_HI, ~bsyAct} :
		syncOut ? `CELF_SYNC : evtOut ? evtWord :
		pairOut ? {nextHw, lo_q} : {`CELF_FILL, lo_q};
	////////////////////////////////////////////////////////////////////
	// software register writes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= 9'h000;
			pol_q <= 2'h0;
			any_q <= 17'h0;
			start_q <= 16'h0;
			win_q <= `CELF_WIN_RST;
			tmo_q <= `CELF_TMO_RST;
			preLo_q <= 32'h0;
		end else if (regReq.wr) begin
			if (hit(regReq.addr, `CELF_A_CTRL)) ctrl_q <= regReq.wrData[8:0];
			if (hit(regReq.addr, `CELF_A_POL)) pol_q <= regReq.wrData[1:0];
			if (hit(regReq.addr, `CELF_A_ANY)) any_q <= regReq.wrData[16:0];
			if (hit(regReq.addr, `CELF_A_START)) start_q <= regReq.wrData[15:0];
			if (hit(regReq.addr, `CELF_A_WIN)) win_q <= regReq.wrData[15:0];
			if (hit(regReq.addr, `CELF_A_TMO)) tmo_q <= regReq.wrData[15:0];
			if (hit(regReq.addr, `CELF_A_RTCLO)) preLo_q <= regReq.wrData;
		end
	end
	// dependent group registers
	for (genvar g = 0; g < 4; g++) begin : gDepReg
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				dep_q[g] <= 17'h0;
			end else if (regReq.wr &&
				hit(regReq.addr, `CELF_A_DEP0 + 6'(4 * g))) begin
				dep_q[g] <= regReq.wrData[16:0];
			end
		end
	end
	// read data, valid only in the cycle after the strobe
	wire [5:0] ra = regReq.addr;
	wire [31:0] rdMux =
		hit(ra, `CELF_A_CTRL) ? {23'h0, ctrl_q} :
		hit(ra, `CELF_A_POL) ? {30'h0, pol_q} :
		hit(ra, `CELF_A_ANY) ? {15'h0, any_q} :
		hit(ra, `CELF_A_START) ? {16'h0, start_q} :
		hit(ra, `CELF_A_WIN) ? {16'h0, win_q} :
		hit(ra, `CELF_A_TMO) ? {16'h0, tmo_q} :
		hit(ra, 6'h18) ? {15'h0, dep_q[0]} :
		hit(ra, 6'h1C) ? {15'h0, dep_q[1]} :
		hit(ra, 6'h20) ? {15'h0, dep_q[2]} :
		hit(ra, 6'h24) ? {15'h0, dep_q[3]} :
		hit(ra, `CELF_A_RTCLO) ? rtc_q[31:0] :
		hit(ra, `CELF_A_RTCHI) ? {16'h0, rtc_q[47:32]} :
		hit(ra, `CELF_A_STAT) ? {st_q, fifoFull, 11'h0, ~bsyAct} : 32'h0;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) regRdData <= 32'h0;
		else regRdData <= regReq.rd ? rdMux : 32'h0;
	end
	////////////////////////////////////////////////////////////////////
	// real-time clock: preset on high write, 20 MHz or external steps
	wire [5:0] accSum = {1'b0, acc_q} + 6'(`CELF_RTC_MHZ);
	wire intTick = accSum >= 6'(`CELF_CLK_MHZ);
	wire rtcTick = rtcOn && (ctrl_q[`CELF_C_REXT] ? extTick : intTick);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rtc_q <= 48'h0;
			acc_q <= 5'h0;
		end else begin
			acc_q <= intTick ? 5'(accSum - 6'(`CELF_CLK_MHZ)) : accSum[4:0];
			if (regReq.wr && hit(regReq.addr, `CELF_A_RTCHI))
				rtc_q <= {regReq.wrData[15:0], preLo_q};
			else if (rtcTick)
				rtc_q <= rtc_q - 48'h1;
		end
	end
	// millisecond base and reduction count
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ms_q <= 16'h0;
			red_q <= 10'h0;
			tmrPend_q <= 1'b0;
			needSync_q <= 1'b1;
		end else begin
			ms_q <= (msTick || !run) ? 16'h0 : ms_q + 16'h1;
			if (msTick) red_q <= tmrDue ? 10'h0 : red_q + 10'h1;
			tmrPend_q <= tmrDue || (tmrPend_q && !tmrOut);
			needSync_q <= tmrOut || (needSync_q && !syncOut);
		end
	end
	////////////////////////////////////////////////////////////////////
	// samples: zero on busy join, value on ready
	for (genvar c = 0; c < NCH; c++) begin : gSmp
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) smp_q[c] <= 16'h0;
			else if (capMask[c]) smp_q[c] <= datS2_q[16*c +: 16];
			else if (joinB[c]) smp_q[c] <= 16'h0;
		end
	end
	// sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= celf_pkg::ST_IDLE;
			{cnt_q, toc_q, hit_q, done_q} <= 64'h0;
			{dmask_q, left_q, lo_q} <= 48'h0;
			{vetHit_q, fill_q, loHeld_q} <= 3'h0;
			{eph_q, rtcLeft_q} <= 4'h0;
			rtcCap_q <= 48'h0;
		end else begin
			hit_q <= hit_q | joinB;
			done_q <= done_q | capCoin;
			if (stWin && vetEdge) vetHit_q <= 1'b1;
			if (cnt_q != 16'h0) cnt_q <= cnt_q - 16'h1;
			if (toc_q != 16'h0) toc_q <= toc_q - 16'h1;
			unique case (st_q)
				celf_pkg::ST_IDLE: begin
					if (openWin) begin
						st_q <= celf_pkg::ST_WIN;
						cnt_q <= win_q;
						toc_q <= tmo_q;
						hit_q <= startHit;
						done_q <= 16'h0;
						vetHit_q <= 1'b0;
						rtcCap_q <= rtc_q;
					end else if (goSingle) begin
						hit_q <= capSingle;
						rtcCap_q <= rtc_q;
					end
				end
				celf_pkg::ST_WIN: begin
					if (winEnd) st_q <= celf_pkg::ST_WAIT;
				end
				celf_pkg::ST_WAIT: begin
					if (waitDone && !accept) st_q <= celf_pkg::ST_IDLE;
				end
				celf_pkg::ST_EMIT: begin
					if (syncOut) eph_q <= 2'h1;
					if (evtOut) eph_q <= 2'h2;
					if (halfStep) begin
						if (rtcLeft_q != 2'h0) rtcLeft_q <= rtcLeft_q - 2'h1;
						else if (fill_q) fill_q <= 1'b0;
						else left_q <= left_q & (left_q - 16'h1);
						lo_q <= nextHw;
						loHeld_q <= !loHeld_q;
					end
					if (flushOut) loHeld_q <= 1'b0;
					if (emitEnd) st_q <= celf_pkg::ST_IDLE;
				end
			endcase
			// load an event for emission, the ready channels in single mode, else every busy member channel with or without data
			if (goEmit) begin
				st_q <= celf_pkg::ST_EMIT;
				dmask_q <= goSingle ? capSingle : hit_q;
				left_q <= goSingle ? capSingle : hit_q;
				fill_q <= goSingle ? ^capSingle : ^hit_q;
				rtcLeft_q <= rtcOn ? 2'h3 : 2'h0;
				eph_q <= syncNeeded ? 2'h0 : 2'h1;
				loHeld_q <= 1'b0;
			end
		end
	end
	// output word register, held while the host fifo is full
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			outWord_q <= 32'h0;
			outValid_q <= 1'b0;
		end else begin
			if (wordOut) outWord_q <= nextWord;
			outValid_q <= wordOut || (outValid_q && !listReady);
		end
	end
	assign listOut = {outValid_q, outWord_q};
	////////////////////////////////////////////////////////////////////
	// checks
	AST_HALT_FULL: assert property (@(posedge core_clk) disable iff (!rstn)
		fifoFull |=> outValid_q && $stable(outWord_q))
		else $error("stream moved while full");
	AST_NO_TIMER_IN_EVT: assert property (@(posedge core_clk)
		disable iff (!rstn) stEmit |-> !tmrOut)
		else $error("timer word inside event");
	AST_SYNC_FIRST: assert property (@(posedge core_clk) disable iff (!rstn)
		tmrOut |=> needSync_q && !evtOut)
		else $error("event word without sync");
	AST_EVT_FLAGS: assert property (@(posedge core_clk) disable iff (!rstn)
		evtOut |=> !outWord_q[30] && outWord_q[`CELF_EB_FILL] ==
		^outWord_q[15:0] && outWord_q[`CELF_EB_RTC] == $past(rtcOn))
		else $error("event word flags wrong");
	AST_TIMER_WORD: assert property (@(posedge core_clk) disable iff (!rstn)
		tmrOut |=> outWord_q[31:16] == `CELF_TMR_HI)
		else $error("timer word header wrong");
	AST_START_ONLY: assert property (@(posedge core_clk) disable iff (!rstn)
		stIdle && (startHit == 16'h0) |=> !stWin)
		else $error("window opened without starter");
	AST_WIN_LEN: assert property (@(posedge core_clk) disable iff (!rstn)
		openWin && win_q == 16'h2 && !vetEdge ##1 !vetNow [*2]
		|=> stWin ##1 stWait)
		else $error("window length wrong");
	AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!rstn)
		stWait && toc_q == 16'h0 |=> !stWait)
		else $error("ready timeout not honoured");
	AST_SINGLE: assert property (@(posedge core_clk) disable iff (!rstn)
		stIdle && run && !coinc && rdyEdge != 16'h0 |=> stEmit
		&& dmask_q == $past(rdyEdge))
		else $error("single conversion not taken");
endmodule

// File: include/celf_regs.svh
// Purpose: constants of the coincidence list framer
// Assumes: byte offsets on a 32-bit register port
// Notes: all timing counts derive from the core clock rate
`ifndef CELF_REGS_SVH
`define CELF_REGS_SVH
`define CELF_A_CTRL 6'h00
`define CELF_A_POL 6'h04
`define CELF_A_ANY 6'h08
`define CELF_A_START 6'h0C
`define CELF_A_WIN 6'h10
`define CELF_A_TMO 6'h14
`define CELF_A_DEP0 6'h18
`define CELF_A_RTCLO 6'h28
`define CELF_A_RTCHI 6'h2C
`define CELF_A_STAT 6'h30
`define CELF_C_RUN 0
`define CELF_C_COINC 1
`define CELF_C_RED 2
`define CELF_C_VEN 4
`define CELF_C_VNEG 5
`define CELF_C_VEND 6
`define CELF_C_RTC 7
`define CELF_C_REXT 8
`define CELF_WIN_RST 16'h0032
`define CELF_TMO_RST 16'h0FA0
`define CELF_TMR_HI 16'h4000
`define CELF_SYNC 32'hFFFFFFFF
`define CELF_FILL 16'hFFFF
`define CELF_EB_FILL 31
`define CELF_EB_RTC 28
`define CELF_MS_NS 1000000
`define CELF_CLK_NS 40
`define CELF_CLK_MHZ 25
`define CELF_RTC_MHZ 20
`endif

// File: include/celf_pkg.sv
// Purpose: types of the coincidence list framer
// Assumes: one clock domain
// Notes: one-hot sequencer states
package celf_pkg;
	// register port request
	typedef struct packed {
		logic [5:0] addr;
		logic [31:0] wrData;
		logic wr;
		logic rd;
	} celf_req_t;
	// list stream word toward the host fifo
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} celf_word_t;
	// event sequencer
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WIN = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_EMIT = 4'b1000
	} celf_st_t;
endpackage

// File: verification/celf_conv_model.sv
// Purpose: model of the converter bank at the framer's handshake pins
// Assumes: one conversion at a time per channel, fixed ready delay
// Notes: sample lines show the inverted value while ready is inactive
`timescale 1ns/1ns
module celf_conv_model (
	// clock
	input wire logic core_clk,
	// bench control
	input wire logic [1:0] pol,
	input wire logic [15:0] fire,
	input wire logic [15:0] skipReady,
	input wire logic [15:0] holdBusy,
	input wire logic useBusy,
	input wire logic [255:0] sampleVal,
	// converter pins
	output logic [15:0] busyIn,
	output logic [15:0] conversionReadyIn,
	output logic [255:0] sampleIn
);
	localparam logic [7:0] RDY_AT = 8'h0A; // ready from this count step, nine cycles after busy
	logic [7:0] cnt [16] = '{default: 8'h00}; // conversion step
	logic [15:0] busyAct; // busy asserted
	logic [15:0] rdyAct; // ready asserted
	// busy first, ready later, both drop together
	always @(posedge core_clk) begin
		for (int i = 0; i < 16; i++) begin
			if (fire[i]) begin
				cnt[i] <= 8'h01;
			end else if (cnt[i] != 8'h00) begin
				cnt[i] <= (cnt[i] == RDY_AT + 8'h04) ? 8'h00 : cnt[i] + 8'h01;
			end
		end
	end
	// pin levels; a sample is only valid beside ready
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			busyAct[i] = holdBusy[i] | (useBusy & (cnt[i] != 8'h00));
			rdyAct[i] = !skipReady[i] && cnt[i] >= RDY_AT;
			sampleIn[16*i +: 16] = rdyAct[i] ? sampleVal[16*i +: 16] :
				~sampleVal[16*i +: 16];
		end
	end
	assign busyIn = busyAct ^ {16{pol[1]}};
	assign conversionReadyIn = rdyAct ^ {16{pol[0]}};
endmodule

// File: verification/tb_coincidence_event_list_framer.sv
// Purpose: self-checking bench of the list framer core
// Assumes: timer tick shortened to 20 core cycles
// Notes: timer words are checked apart from the event queue
`timescale 1ns/1ns
`include "celf_regs.svh"
module tb_coincidence_event_list_framer;
	localparam int MS = 20; // cycles per timer tick
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	celf_pkg::celf_req_t regReq = '0;
	logic [31:0] regRdData;
	logic [15:0] conversionReadyIn, busyIn;
	logic [255:0] sampleIn;
	logic vetoInput = 1'b0; // veto pin, positive polarity
	logic rtcExtClk = 1'b0;
	celf_pkg::celf_word_t listOut;
	logic listReady = 1'b0;
	// model controls
	logic [1:0] pol = 2'b00;
	logic [15:0] fire = '0, skipReady = '0, holdBusy = '0;
	logic useBusy = 1'b0;
	logic [255:0] sampleVal = '0;
	// scoreboard: {last, dont-care mask, word}
	logic [64:0] expQ [$];
	logic [64:0] e;
	int num_errors = 0, cmp_count = 0, tmrCount = 0, seed = 45153;
	logic liveKnown = 1'b0, sawTimer = 1'b1, inEvent = 1'b0;
	logic stallQ = 1'b0;
	logic [15:0] liveExp = 16'hFFDF; // channel 5 held busy
	logic [31:0] heldQ = '0, rnd, rd;
	logic [15:0] s [5];
	initial forever #20 core_clk = ~core_clk;
	celf_core #(.MS_CYC(MS)) dut (.core_clk(core_clk), .rstn(rstn),
		.regReq(regReq), .regRdData(regRdData),
		.conversionReadyIn(conversionReadyIn), .busyIn(busyIn),
		.sampleIn(sampleIn), .vetoInput(vetoInput), .rtcExtClk(rtcExtClk),
		.listOut(listOut), .listReady(listReady));
	celf_conv_model conv (.core_clk(core_clk), .pol(pol), .fire(fire),
		.skipReady(skipReady), .holdBusy(holdBusy), .useBusy(useBusy),
		.sampleVal(sampleVal), .busyIn(busyIn),
		.conversionReadyIn(conversionReadyIn), .sampleIn(sampleIn));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// register port cycles
	task automatic regWr(input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		regReq <= '0;
	endtask
	task automatic regRd(input logic [5:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regReq <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		regReq <= '0;
		#1 d = regRdData;
	endtask
	// one-cycle conversion start on the masked channels
	task automatic pulse(input logic [15:0] m);
		@(posedge core_clk);
		fire <= m;
		@(posedge core_clk);
		fire <= '0;
	endtask
	task automatic want(input logic last, input logic [31:0] dc,
		input logic [31:0] w);
		expQ.push_back({last, dc, w});
	endtask
	// fresh samples below the timer tag value
	task automatic newSamples;
		logic [31:0] r;
		for (int c = 0; c < 5; c++) begin
			r = $random(seed);
			s[c] = {2'b00, r[13:0]};
			sampleVal[16*c +: 16] <= s[c];
		end
	endtask
	// program groups, fire one or two channels, let the event drain
	task automatic scen(input logic [31:0] any, input logic [31:0] st,
		input logic [31:0] dep, input logic [15:0] m1, input logic [15:0] m2);
		regWr(`CELF_A_ANY, any);
		regWr(`CELF_A_START, st);
		regWr(`CELF_A_DEP0, dep);
		pulse(m1);
		if (m2 != '0) pulse(m2);
		repeat (150) @(posedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////
	// host side stalls at random; external clock pin wanders
	always @(posedge core_clk) begin
		rnd = $random(seed);
		listReady <= rnd[1:0] != 2'b00;
		rtcExtClk <= rnd[2];
	end
	// stream monitor: timer words apart, events off the queue
	always @(posedge core_clk) begin
		if (rstn) begin
			if (stallQ) check("heldWord", listOut.data, heldQ);
			stallQ <= listOut.valid && !listReady;
			heldQ <= listOut.data;
			if (listOut.valid && listReady) begin
				if (listOut.data[31:16] === `CELF_TMR_HI) begin
					check("timerInEvent", {31'h0, inEvent}, 32'h0);
					if (liveKnown) check("timer", listOut.data, {`CELF_TMR_HI, liveExp});
					tmrCount++;
					sawTimer = 1'b1;
				end else if (sawTimer) begin
					check("sync", listOut.data, `CELF_SYNC);
					sawTimer = 1'b0;
				end else if (expQ.size() == 0) begin
					num_errors++;
					$display("[ERR] extraWord expected none seen %h", listOut.data);
				end else begin
					e = expQ.pop_front();
					check("event", listOut.data | e[63:32], e[31:0] | e[63:32]);
					inEvent = !e[64];
				end
			end
		end
	end
	// watchdog
	initial begin
		repeat (90000) @(posedge core_clk);
		num_errors++;
		$display("[ERR] watchdog expected end seen hang");
		wrap_up();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		int f, t0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		regRd(`CELF_A_WIN, rd);
		check("winReset", rd, {16'h0, `CELF_WIN_RST});
		regRd(`CELF_A_TMO, rd);
		check("tmoReset", rd, {16'h0, `CELF_TMO_RST});
		regRd(6'h38, rd);
		check("unmapped", rd, 32'h0);
		regWr(`CELF_A_WIN, 32'h10);
		regWr(`CELF_A_TMO, 32'h40);
		regRd(`CELF_A_WIN, rd);
		check("winSet", rd, 32'h10);
		holdBusy <= 16'h0020;
		// single mode, both handshake polarities
		for (int p = 0; p < 2; p++) begin
			regWr(`CELF_A_CTRL, 32'h0);
			liveKnown <= 1'b0;
			regWr(`CELF_A_POL, {30'h0, p[0], p[0]});
			pol <= {p[0], p[0]};
			repeat (10) @(posedge core_clk);
			regWr(`CELF_A_CTRL, 32'h1);
			liveKnown <= 1'b1;
			newSamples();
			want(1'b0, 32'h0, 32'h80000010);
			want(1'b1, 32'h0, {s[4], `CELF_FILL});
			pulse(16'h0010);
			repeat (100) @(posedge core_clk);
		end
		// every timer reduction factor
		for (int k = 0; k < 4; k++) begin
			regWr(`CELF_A_CTRL, {28'h0, k[1:0], 2'b01});
			f = (k == 0) ? 1 : (k == 1) ? 10 : (k == 2) ? 100 : 1000;
			t0 = tmrCount;
			repeat (2 * f * MS) @(posedge core_clk);
			check("timerRate", {31'h0, (tmrCount - t0) inside {[1:3]}}, 32'h1);
		end
		// coincidence mode
		regWr(`CELF_A_CTRL, 32'h0);
		liveKnown <= 1'b0;
		holdBusy <= '0;
		useBusy <= 1'b1;
		regWr(`CELF_A_CTRL, 32'h3);
		newSamples();
		want(1'b0, 32'h0, 32'h00000003);
		want(1'b1, 32'h0, {s[1], s[0]});
		scen(32'h3, 32'h1, 32'h0, 16'h0001, 16'h0002);
		scen(32'h3, 32'h1, 32'h0, 16'h0002, 16'h0000);
		want(1'b0, 32'h0, 32'h80000001);
		want(1'b1, 32'h0, {s[0], `CELF_FILL});
		scen(32'h3, 32'h1, 32'h0, 16'h0001, 16'h0000);
		scen(32'h0, 32'h4, 32'hC, 16'h0004, 16'h0000);
		want(1'b0, 32'h0, 32'h0000000C);
		want(1'b1, 32'h0, {s[3], s[2]});
		scen(32'h0, 32'h4, 32'hC, 16'h0004, 16'h0008);
		skipReady <= 16'h0008;
		want(1'b0, 32'h0, 32'h0000000C);
		want(1'b1, 32'h0, {16'h0, s[2]});
		scen(32'hC, 32'h4, 32'h0, 16'h0004, 16'h0008);
		skipReady <= '0;
		// veto as group member: no edge no event, edge in window event
		regWr(`CELF_A_CTRL, 32'h13);
		scen(32'h0, 32'h1, 32'h10001, 16'h0001, 16'h0000);
		want(1'b0, 32'h0, 32'h80000001);
		want(1'b1, 32'h0, {s[0], `CELF_FILL});
		pulse(16'h0001);
		repeat (4) @(posedge core_clk);
		vetoInput <= 1'b1;
		repeat (150) @(posedge core_clk);
		vetoInput <= 1'b0;
		// clock parts, counting down from a preset
		regWr(`CELF_A_RTCLO, 32'h80000000);
		regWr(`CELF_A_RTCHI, 32'h0);
		regWr(`CELF_A_CTRL, 32'h83);
		want(1'b0, 32'h0, 32'h90000001);
		want(1'b0, 32'h0000FFFF, 32'h7FFF0000);
		want(1'b0, 32'h0, {`CELF_FILL, 16'h0});
		want(1'b1, 32'h0, {`CELF_FILL, s[0]});
		scen(32'h1, 32'h1, 32'h0, 16'h0001, 16'h0000);
		regRd(`CELF_A_RTCLO, rd);
		check("rtcDown", {31'h0, rd < 32'h80000000}, 32'h1);
		check("expLeft", 32'(expQ.size()), 32'h0);
		wrap_up();
	end
endmodule
